/* hw/dac_pkg.sv */
// Purpose: Shared constants for the DAC output control block
// Assumes: 8-bit register port, one byte per register index
// Notes:   Register offsets are index values on the plain register port
package dac_pkg;
	localparam int          DAC_CODE_W        = 8;
	localparam logic [1:0]  DAC_MODE_OFS      = 2'h0;
	localparam logic [1:0]  DAC_VALUE_OFS     = 2'h1;
	localparam logic [1:0]  DAC_PWR_OFS       = 2'h2;
	localparam logic [1:0]  DAC_STAT_OFS      = 2'h3;
	localparam logic [7:0]  DAC_MODE_RST      = 8'h00;
	localparam logic [7:0]  DAC_VALUE_RST     = 8'h00;
	localparam int          DAC_MODE_SEL_BIT  = 0;
	localparam int          DAC_ENABLE_BIT    = 7;
	localparam logic [7:0]  DAC_MODE_MASK     = 8'h81;
	localparam int          DAC_PWR_STOP_BIT  = 0;
	localparam int          DAC_PWR_IDLE_BIT  = 1;
	localparam int          DAC_STAT_LIVE_BIT = 0;
	localparam int          DAC_STAT_RT_BIT   = 1;
	localparam int          DAC_STAT_ARM_BIT  = 2;
	localparam int          DAC_CONV_NS       = 3000;
	localparam int          DAC_CLK_NS        = 25;
	localparam int          DAC_CONV_CYC      = DAC_CONV_NS / DAC_CLK_NS;
	localparam logic [6:0]  DAC_CONV_CNT      = 7'(DAC_CONV_CYC);
endpackage

/* hw/dac_conv_if.sv */
// Purpose: Carries a conversion request and its code to the ladder driver
// Assumes: Single clock domain
// Notes:   load is a one-cycle pulse
`timescale 1ns/100ps
interface dac_conv_if;
	logic       load;
	logic [7:0] code;
	logic       hiz;
	logic       busy;
	modport ctrl (output load, output code, output hiz, input busy);
	modport ladder (input load, input code, input hiz, output busy);
endinterface

/* hw/dac_ladder.sv */
// Purpose: Holds the converted code on the ladder and times settling
// Assumes: Requests come from dac_output_control on the same clock
// Notes:   Busy covers the maximum settling time of the analog stage
`timescale 1ns/100ps
module dac_ladder (
	input  wire logic     clk_sys,
	input  wire logic     rstn,
	dac_conv_if.ladder    cv,
	output logic [7:0]    ladder_code,
	output logic          ladder_oe
);
	logic [7:0] code_r;
	logic [6:0] cnt_r;

	// Latch a new code; the old one is held until the next load
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			code_r <= dac_pkg::DAC_VALUE_RST;
			cnt_r  <= 7'h00;
		end else begin
			if (cv.load) begin
				code_r <= cv.code;
				cnt_r  <= dac_pkg::DAC_CONV_CNT;
			end else if (cnt_r != 7'h00) begin
				cnt_r <= cnt_r - 7'h01;
			end
		end
	end

	assign cv.busy     = (cnt_r != 7'h00);
	assign ladder_code = code_r;
	assign ladder_oe   = !cv.hiz;
endmodule

/* hw/dac_output_control.sv */
// Purpose: Register control of one 8-bit ladder DAC channel
// Assumes: 40 MHz clk_sys, synchronous active-low reset
// Notes:   The analog level is reference * code / 256 on the ladder taps
//
// Overview of operation
// - Output level is reference voltage times code over 256, code 0 to 255.
// - One output channel, 8-bit code held in one value register.
// - Mode register resets to 00H, byte and single-bit access.
// - realtime_mode_sel 0 selects normal mode, 1 selects real-time mode.
// - Real-time mode converts only on timer_compare_trigger.
// - Value register resets to 00H, whole-byte access only.
// - Normal mode: each value write converts and updates the output.
// - Normal mode: setting enable drives output from the held code.
// - Output holds last converted code until the next conversion.
// - Real-time mode: each trigger converts value register onto analog_out_pin.
// - Real-time output undefined between enable and first trigger.
// - Stop mode halts converter and floats the analog output.
// - Idle and subclock keep converting; software may clear enable.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
module dac_output_control (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_bit_mask,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       timer_compare_trigger,
	input  wire logic       stop_mode,
	output logic [7:0]      analog_out_code,
	output logic            analog_out_oe,
	output logic            conv_busy
);
	logic [7:0] dac_mode_reg_r;
	logic [7:0] dac_value_reg_r;
	logic [7:0] rdata_r;
	logic       armed_r;
	logic [2:0] stop_sync_r;
	logic       stop_r;
	logic [7:0] mode_nxt;
	logic [7:0] rdata_nxt;
	logic       armed_nxt;
	logic [7:0] code_nxt;
	logic       load_nxt;

	dac_conv_if cv ();

	// Address decode
	wire wr_mode  = reg_wr && (reg_addr == dac_pkg::DAC_MODE_OFS);
	wire wr_value = reg_wr && (reg_addr == dac_pkg::DAC_VALUE_OFS);

	// Mode fields
	wire rt_mode = dac_mode_reg_r[dac_pkg::DAC_MODE_SEL_BIT];
	wire enable  = dac_mode_reg_r[dac_pkg::DAC_ENABLE_BIT];

	// Bit writes merge only the masked bits; a full byte write uses mask FF
	assign mode_nxt = (dac_mode_reg_r & ~reg_bit_mask) | (reg_wdata & reg_bit_mask & dac_pkg::DAC_MODE_MASK);

	wire enable_rise = wr_mode && mode_nxt[dac_pkg::DAC_ENABLE_BIT] && !enable;
	wire new_rt      = wr_mode ? mode_nxt[dac_pkg::DAC_MODE_SEL_BIT] : rt_mode;

	// Trigger comes from the timer on this clock; no synchroniser needed
	wire rt_fire = rt_mode && enable && timer_compare_trigger && !stop_r;

	// Normal-mode conversions: value writes while enabled, or enabling
	wire nm_fire_wr = !rt_mode && enable && wr_value && !stop_r;
	wire nm_fire_en = enable_rise && !new_rt && !stop_r;

	// Code selection; a same-cycle write wins so the newest code is shown
	assign code_nxt = wr_value ? reg_wdata : dac_value_reg_r;
	assign load_nxt = rt_fire || nm_fire_wr || nm_fire_en;

	// Real-time output counts as valid once the first trigger lands
	assign armed_nxt = !(enable && rt_mode) ? 1'b0 : (armed_r || rt_fire);

	// Register read mux; all four offsets of the 2-bit address are mapped
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (reg_addr)
			dac_pkg::DAC_MODE_OFS:  rdata_nxt = dac_mode_reg_r;
			dac_pkg::DAC_VALUE_OFS: rdata_nxt = dac_value_reg_r;
			dac_pkg::DAC_PWR_OFS:   rdata_nxt = {7'h00, stop_r};
			dac_pkg::DAC_STAT_OFS:  rdata_nxt = {5'h00, armed_r, rt_mode, cv.busy};
		endcase
	end

	// Software-visible registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dac_mode_reg_r  <= dac_pkg::DAC_MODE_RST;
			dac_value_reg_r <= dac_pkg::DAC_VALUE_RST;
		end else begin
			if (wr_mode)
				dac_mode_reg_r <= mode_nxt;
			if (wr_value)
				dac_value_reg_r <= reg_wdata;
		end
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			rdata_r <= 8'h00;
		else if (reg_rd)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= 8'h00;
	end

	// Stop request comes from the power controller pin: three-stage filter
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			stop_sync_r <= 3'h0;
			stop_r      <= 1'b0;
			armed_r     <= 1'b0;
		end else begin
			stop_sync_r <= {stop_sync_r[1:0], stop_mode};
			if (stop_sync_r[1] == stop_sync_r[2])
				stop_r <= stop_sync_r[2];
			armed_r <= armed_nxt;
		end
	end

	// Idle and subclock are not inputs: only stop halts conversion
	assign cv.load = load_nxt;
	assign cv.code = code_nxt;
	assign cv.hiz  = stop_r;

	dac_ladder u_ladder (
		.clk_sys     (clk_sys),
		.rstn        (rstn),
		.cv          (cv.ladder),
		.ladder_code (analog_out_code),
		.ladder_oe   (analog_out_oe)
	);

	assign reg_rdata = rdata_r;
	assign conv_busy = cv.busy;
endmodule

/* verif/dac_trig_src.sv */
// Purpose: Timer compare pulse source facing the converter
// Assumes: Same clock as the converter
// Notes:   Silent until run is raised, as setup must finish first
`timescale 1ns/100ps
module dac_trig_src #(parameter int PERIOD = 40) (
	input  wire logic clk_sys,
	input  wire logic run,
	output logic      trig = 1'b0
);
	int cnt = 0;
	// One pulse per period, the only trigger real-time mode gets
	always @(posedge clk_sys) begin
		cnt <= run ? (cnt + 1) % PERIOD : 0;
		trig <= run && cnt == PERIOD - 2;
	end
endmodule

/* verif/dac_output_control_sva.sv */
// Purpose: Port checks for the converter control
// Assumes: One clock, synchronous active-low reset
// Notes:   Mode and value are shadowed from bus writes
`timescale 1ns/100ps
module dac_output_control_sva (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_bit_mask,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       timer_compare_trigger,
	input wire logic       stop_mode,
	input wire logic [7:0] analog_out_code,
	input wire logic       analog_out_oe,
	input wire logic       conv_busy
);
	logic [7:0] mode_r;
	logic [7:0] val_r;
	wire        wr_val   = reg_wr && reg_addr == 2'h1;
	wire  [7:0] val_nxt  = wr_val ? reg_wdata : val_r;
	wire  [7:0] mode_nxt = (reg_wr && reg_addr == 2'h0) ? (mode_r & ~reg_bit_mask) | (reg_wdata & reg_bit_mask) : mode_r;
	// The pin enable follows the filtered stop, so a raw stop edge cannot fake a refusal
	wire        rt_on    = mode_r == 8'h81 && analog_out_oe;
	// Shadows; only the live bits are kept
	always_ff @(posedge clk_sys) begin
		mode_r <= rstn ? mode_nxt & 8'h81 : 8'h00;
		val_r <= rstn ? val_nxt : 8'h00;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_norm_write_conv: assert property (wr_val && mode_r == 8'h80 && analog_out_oe |=> analog_out_code == $past(reg_wdata) && conv_busy) else $error("no conversion on write");
	a_rt_trig_conv: assert property (timer_compare_trigger && rt_on |=> analog_out_code == $past(val_nxt)) else $error("no trigger conversion");
	a_rt_write_hold: assert property (wr_val && mode_r[0] && !timer_compare_trigger |=> $stable(analog_out_code)) else $error("write moved output");
	a_code_hold: assert property (!reg_wr && !timer_compare_trigger |=> $stable(analog_out_code)) else $error("code drifted");
	a_stop_float: assert property (stop_mode [*5] |-> !analog_out_oe) else $error("pin driven in stop");
	a_run_drive: assert property (!stop_mode [*5] |-> analog_out_oe) else $error("pin floating");
	a_mode_read: assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata == $past(mode_r)) else $error("mode read");
	a_value_read: assert property (reg_rd && reg_addr == 2'h1 |=> reg_rdata == $past(val_r)) else $error("value read");
	c_trig: cover property (timer_compare_trigger && rt_on);
	c_norm: cover property (wr_val && mode_r == 8'h80);
	c_stop: cover property (stop_mode [*5]);
endmodule
bind dac_output_control dac_output_control_sva i_sva (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_bit_mask(reg_bit_mask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.timer_compare_trigger(timer_compare_trigger), .stop_mode(stop_mode), .analog_out_code(analog_out_code),
	.analog_out_oe(analog_out_oe), .conv_busy(conv_busy));

/* verif/test_dac_output_control.sv */
// Purpose: Self-checking bench for the converter control
// Assumes: 40 MHz clock, reset held 16 cycles
// Notes:   Expected codes come from an integer model
`timescale 1ns/100ps
module test_dac_output_control;
	logic       clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stop_mode = 1'b0, run = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_bit_mask = 8'hFF, reg_rdata, analog_out_code;
	logic       analog_out_oe, conv_busy, trig;
	logic [31:0] seed = 32'h6B89CF83;
	int         n_errors = 0, n_compared = 0, mode_m = 0, val_m = 0, code_m = 0;
	dac_output_control i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_bit_mask(reg_bit_mask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_compare_trigger(trig), .stop_mode(stop_mode), .analog_out_code(analog_out_code),
		.analog_out_oe(analog_out_oe), .conv_busy(conv_busy));
	dac_trig_src i_trig (.clk_sys(clk_sys), .run(run), .trig(trig));
	initial forever #12.5 clk_sys = ~clk_sys;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bus write; the model converts only where normal mode allows
	task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic [7:0] m);
		int old;
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_bit_mask <= m;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
		old = mode_m;
		if (a == 2'h0) mode_m = ((mode_m & ~m) | (d & m)) & 8'h81;
		if (a == 2'h1) val_m = d;
		if (mode_m == 8'h80 && (a == 2'h1 || (a == 2'h0 && !old[7]))) code_m = val_m;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#200us;
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(2'h0, 8'h00);
		rd(2'h1, 8'h00);
		wr(2'h3, 8'hFF, 8'hFF);
		rd(2'h3, 8'h00); // Status ignores writes
		wr(2'h1, 8'h5A, 8'hFF);
		chk(analog_out_code, 8'(code_m));
		wr(2'h0, 8'h80, 8'hFF);
		chk(analog_out_code, 8'h5A);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(2'h1, seed[7:0], 8'hFF);
			chk(analog_out_code, 8'(code_m));
			rd(2'h1, seed[7:0]);
		end
		chk({7'h00, conv_busy}, 8'h01);
		$display("normal mode done");
		wr(2'h0, 8'hFF, 8'h01);
		rd(2'h0, 8'h81);
		wr(2'h1, 8'hC3, 8'hFF);
		rd(2'h3, 8'h03);
		@(posedge clk_sys);
		run <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys iff trig);
			#1;
			chk(analog_out_code, 8'(val_m));
			code_m = val_m;
			rd(2'h3, 8'h07);
			wr(2'h1, 8'(i * 8'h35 + 8'h11), 8'hFF);
			chk(analog_out_code, 8'(code_m));
		end
		$display("real-time mode done");
		@(posedge clk_sys);
		run <= 1'b0;
		stop_mode <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk({7'h00, analog_out_oe}, 8'h00);
		rd(2'h2, 8'h01);
		@(posedge clk_sys);
		stop_mode <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		chk({7'h00, analog_out_oe}, 8'h01);
		// Settling flag must drop once the last conversion has had its full time
		repeat (dac_pkg::DAC_CONV_CYC) @(posedge clk_sys);
		#1;
		chk({7'h00, conv_busy}, 8'h00);
		$display("stop mode done");
		complete_run();
	end
endmodule
